//--- src/rms_params.svh
`ifndef RMS_PARAMS_SVH
`define RMS_PARAMS_SVH
// Clock rate in Hz
`define RMS_CLK_HZ 20000000
// Coil pulse length in microseconds
`define RMS_PULSE_US 7000
// Coil pulse length in clock cycles, rounded down
`define RMS_PULSE_CYC ((`RMS_CLK_HZ / 1000000) * `RMS_PULSE_US)
// Default queue depth in entries
`define RMS_FIFO_DEPTH 16
// Default number of relay banks
`define RMS_BANKS 4
// Reset value of the interrupt request
`define RMS_IRQ_RST 1'b0
`endif

//--- src/rms_pkg.sv
package rms_pkg;
  // Sequencer states
  typedef enum logic [2:0] {
    RMS_INIT_OPEN,
    RMS_IDLE,
    RMS_POP,
    RMS_PULSE,
    RMS_DONE
  } rms_state_e;
  // One relay pattern for a bank
  typedef logic [15:0] rms_pattern_t;
endpackage

//--- src/rms_cmd_fifo.sv
`timescale 1ns/1ps
`include "rms_params.svh"
// Paired bank/pattern queue; both halves are written and popped together
module rms_cmd_fifo
  import rms_pkg::*;
#(
  parameter int DEPTH = `RMS_FIFO_DEPTH,
  parameter int BW = 2
) (
  input wire logic clock, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic wr_en, // Write one entry
  input wire logic [BW-1:0] wr_bank, // Bank to store
  input wire rms_pattern_t wr_pattern, // Pattern to store
  input wire logic rd_en, // Pop one entry
  output logic [BW-1:0] rd_bank, // Head bank
  output rms_pattern_t rd_pattern, // Head pattern
  output logic empty_n, // Queue holds data, active low empty
  output logic full // Queue full
);
  localparam int AW = $clog2(DEPTH);
  initial begin
    if (DEPTH < 2 || (1 << AW) != DEPTH) $error("DEPTH must be a power of two >= 2");
  end
  logic [BW-1:0] bank_mem [DEPTH]; // Address half
  rms_pattern_t pat_mem [DEPTH]; // Data half
  logic [AW:0] wptr; // Write pointer with wrap bit
  logic [AW:0] rptr; // Read pointer with wrap bit
  // Storage write
  always_ff @(posedge clock) begin
    if (wr_en && !full) begin
      bank_mem[wptr[AW-1:0]] <= wr_bank;
      pat_mem[wptr[AW-1:0]] <= wr_pattern;
    end
  end
  // Pointers
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= '0;
      rptr <= '0;
    end else begin
      if (wr_en && !full) wptr <= wptr + 1'b1;
      if (rd_en && empty_n) rptr <= rptr + 1'b1;
    end
  end
  assign rd_bank = bank_mem[rptr[AW-1:0]];
  assign rd_pattern = pat_mem[rptr[AW-1:0]];
  assign empty_n = (wptr != rptr);
  assign full = (wptr[AW] != rptr[AW]) && (wptr[AW-1:0] == rptr[AW-1:0]);
endmodule

//--- src/rms_sequencer.sv
`timescale 1ns/1ps
`include "rms_params.svh"
// Overview of operation
// - Commands go into the queue, not executed
// - Acknowledge once the command is stored
// - Stored command starts the relay sequencer
// - Each entry gives one 7 ms pulse
// - One pulse drives a whole 16-relay bank
// - Pop entries while queue not empty
// - Empty queue raises interrupt after last pulse
// - Interrupt once per list, not per relay
// - Reset never drives coils by itself; the code pulses every bank open as soon as reset is released
// - After reset, open every relay
module rms_sequencer
  import rms_pkg::*;
#(
  parameter int BANKS = `RMS_BANKS,
  parameter int DEPTH = `RMS_FIFO_DEPTH,
  parameter int PULSE_CYC = `RMS_PULSE_CYC,
  localparam int BW = (BANKS > 1) ? $clog2(BANKS) : 1
) (
  input wire logic clock, // 20 MHz card clock
  input wire logic rst_n, // Backplane reset, active low
  input wire logic cmd_write, // Bus write strobe, one cycle
  input wire logic [BW-1:0] cmd_bank, // Bank select of the write
  input wire rms_pattern_t cmd_pattern, // Relay pattern of the write
  input wire logic cmd_open, // 1 = open listed relays, 0 = close
  input wire logic irq_ack, // Master acknowledges interrupt, one cycle
  output logic dtack, // Write stored, one cycle pulse
  output logic busy, // Sequencer working
  output logic irq, // Interrupt request, level
  output logic [BANKS-1:0] bank_fire, // Coil pulse per bank
  output rms_pattern_t coil_set, // Close coil drive for fired bank
  output rms_pattern_t coil_reset // Open coil drive for fired bank
);
  initial begin
    if (BANKS < 1 || PULSE_CYC < 1) $error("BANKS and PULSE_CYC must be positive");
  end
  localparam int CW = $clog2(PULSE_CYC + 1);
  localparam logic [CW-1:0] PULSE_LAST = CW'(PULSE_CYC - 1);
  localparam logic [CW-1:0] PULSE_FULL = CW'(PULSE_CYC); // Full pulse length in cycles

  rms_state_e state; // Sequencer state
  logic [CW-1:0] cnt; // Pulse length counter
  logic [BW-1:0] init_bank; // Bank being cleared after reset
  logic [BW-1:0] head_bank; // Queue head bank
  rms_pattern_t head_pat; // Queue head pattern
  logic head_open; // Queue head direction
  logic q_empty_n; // Queue not empty
  logic q_full; // Queue full
  logic pop; // Take head entry
  logic start; // Bus side start request
  logic pending; // Work seen since last idle
  logic [BW:0] head_word; // Queue head, direction above bank
  logic [BANKS-1:0] fire_prev; // Fire lines one cycle back, for checks
  logic [CW-1:0] fire_len; // Cycles the present bank has fired, for checks

  // Queue holds bank, direction and pattern together
  rms_cmd_fifo #(.DEPTH(DEPTH), .BW(BW + 1)) u_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .wr_en(cmd_write),
    .wr_bank({cmd_open, cmd_bank}),
    .wr_pattern(cmd_pattern),
    .rd_en(pop),
    .rd_bank(head_word),
    .rd_pattern(head_pat),
    .empty_n(q_empty_n),
    .full(q_full)
  );

  assign pop = (state == RMS_POP) && q_empty_n;

  // Split the queue head into direction and bank select
  assign head_open = head_word[BW];
  assign head_bank = head_word[BW-1:0];

  // Bus timing: acknowledge the stored write and kick the sequencer
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      dtack <= 1'b0;
      start <= 1'b0;
    end else begin
      dtack <= cmd_write && !q_full;
      start <= cmd_write && !q_full;
    end
  end

  // Sequencer: clear all banks after reset, then drain the queue
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state <= RMS_INIT_OPEN;
      cnt <= '0;
      init_bank <= '0;
    end else begin
      case (state)
        RMS_INIT_OPEN: begin
          // Hold open pulse on each bank in turn
          if (cnt == PULSE_LAST) begin
            cnt <= '0;
            if (int'(init_bank) == BANKS - 1) state <= RMS_IDLE;
            else init_bank <= init_bank + 1'b1;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        RMS_IDLE: begin
          if (start || q_empty_n) state <= RMS_POP;
        end
        RMS_POP: begin
          // Empty flag stops the drain
          if (q_empty_n) state <= RMS_PULSE;
          else state <= RMS_DONE;
        end
        RMS_PULSE: begin
          if (cnt == PULSE_LAST) begin
            cnt <= '0;
            state <= RMS_POP;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        RMS_DONE: state <= RMS_IDLE;
        default: state <= RMS_IDLE;
      endcase
    end
  end

  // Latch the popped entry onto the coil drivers for the pulse
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      bank_fire <= '0;
      coil_set <= '0;
      coil_reset <= '0;
    end else if (state == RMS_INIT_OPEN) begin
      bank_fire <= BANKS'(1) << init_bank;
      coil_set <= '0;
      coil_reset <= 16'hFFFF;
    end else if (pop) begin
      bank_fire <= BANKS'(1) << head_bank;
      coil_set <= head_open ? 16'h0000 : head_pat;
      coil_reset <= head_open ? head_pat : 16'h0000;
    end else if (state != RMS_PULSE || cnt == PULSE_LAST) begin
      // Pulse over, or none due: the last init pulse must not linger
      bank_fire <= '0;
      coil_set <= '0;
      coil_reset <= '0;
    end
  end

  // Interrupt once per drained list
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq <= `RMS_IRQ_RST;
      pending <= 1'b0;
      busy <= 1'b1;
    end else begin
      busy <= (state != RMS_IDLE) || start;
      if (pop) pending <= 1'b1;
      else if (state == RMS_DONE) pending <= 1'b0;
      if (state == RMS_DONE && pending) irq <= 1'b1;
      else if (irq_ack) irq <= 1'b0;
    end
  end

  // Check helper: how long the present bank has been firing
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      fire_prev <= '0;
      fire_len <= '0;
    end else begin
      fire_prev <= bank_fire;
      if (bank_fire == '0) begin
        fire_len <= '0; // Coils at rest
      end else if (bank_fire != fire_prev) begin
        fire_len <= CW'(1); // New bank starts its pulse
      end else begin
        fire_len <= fire_len + 1'b1; // Same bank still driven
      end
    end
  end

  // Acknowledge follows each accepted write by one cycle
  dtack_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    (cmd_write && !q_full) |=> dtack) else $error("dtack missing");
  // Pulse stands at least eight cycles after a pop
  pulse_len_a: assert property (@(posedge clock) disable iff (!rst_n)
    (pop) |=> (bank_fire != '0) [*8]) else $error("pulse too short");
  // No pulse outlasts its full length
  fire_max_a: assert property (@(posedge clock) disable iff (!rst_n)
    fire_len <= PULSE_FULL) else $error("pulse too long");
  // Every pulse, init or queued, ends after exactly its full length
  fire_end_a: assert property (@(posedge clock) disable iff (!rst_n)
    (fire_prev != '0 && bank_fire != fire_prev) |-> fire_len == PULSE_FULL)
    else $error("pulse length wrong");
  // Only one bank fires at a time
  one_bank_a: assert property (@(posedge clock) disable iff (!rst_n)
    $onehot0(bank_fire)) else $error("several banks fired");
  // An empty queue ends the drain with the coils at rest
  pop_empty_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state == RMS_POP && !q_empty_n) |=> (state == RMS_DONE && bank_fire == '0))
    else $error("drain did not stop on empty");
  // Coils never fire while the sequencer reports idle
  busy_fire_a: assert property (@(posedge clock) disable iff (!rst_n)
    (bank_fire != '0) |-> busy) else $error("fire while not busy");
  // Interrupt rises only with the queue empty or just after the done state, and with coils idle
  irq_after_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(irq) |-> (!q_empty_n || $past(state) == RMS_DONE) && bank_fire == '0)
    else $error("irq during work");
  // Service clears the interrupt unless another list ends at once
  irq_clear_a: assert property (@(posedge clock) disable iff (!rst_n)
    (irq && irq_ack && !(state == RMS_DONE && pending)) |=> !irq)
    else $error("irq not cleared");
  // Pop is followed by a pulse state, not another pop
  no_double_a: assert property (@(posedge clock) disable iff (!rst_n)
    pop |=> state == RMS_PULSE) else $error("pop not followed by pulse");
  // Accepted write starts the sequencer within a few cycles
  start_seq_a: assert property (@(posedge clock) disable iff (!rst_n)
    (cmd_write && !q_full && state == RMS_IDLE) |-> ##[1:3] state == RMS_POP)
    else $error("sequencer not started");
  // Init drives only open coils
  init_open_a: assert property (@(posedge clock) disable iff (!rst_n)
    (state == RMS_INIT_OPEN && bank_fire != '0) |-> coil_set == '0)
    else $error("close drive during init");
endmodule

//--- tb/rms_host_model.sv
`timescale 1ns/1ps
// Master CPU side: services the interrupt after a chosen delay
module rms_host_model (
  input wire logic clock, // Card clock
  input wire logic rst_n, // Reset, active low
  input wire logic [3:0] dly, // Service delay, cycles
  input wire logic irq, // Interrupt from the card
  output logic irq_ack // One-cycle service pulse
);
  logic [3:0] n; // Wait counter
  // Counts while irq stands, then acknowledges once
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      n <= 4'h0;
      irq_ack <= 1'b0;
    end else if (irq_ack) begin
      n <= 4'h0;
      irq_ack <= 1'b0;
    end else if (irq) begin
      if (n == dly) begin
        irq_ack <= 1'b1;
      end else begin
        n <= n + 4'h1;
      end
    end
  end
endmodule

//--- tb/test_relay_matrix_command_sequencer.sv
`timescale 1ns/1ps
module test_relay_matrix_command_sequencer;
  import rms_pkg::*;
  logic clock = 0, rst_n = 0, cmd_write = 0, cmd_open = 0; // Stimulus
  logic irq_ack, dtack, busy, irq, w1 = 0, iq = 0; // Outputs and history
  logic [1:0] cmd_bank = 0; // Bank select
  rms_pattern_t cmd_pattern = 0, coil_set, coil_reset; // Patterns
  logic [3:0] bank_fire, fire_q = 0, dly = 0; // Fire lines and delay
  logic [35:0] notes[$]; // Expected {fire, set, reset}
  logic [35:0] coil_word; // Observed {fire, set, reset}
  logic [31:0] rng = 14; // Random state
  int failures = 0, comparisons = 0, plen = 0, irqs = 0, k; // Counters
  always #25 clock = ~clock;
  rms_sequencer #(.PULSE_CYC(10)) u_rms_sequencer (.clock(clock), .rst_n(rst_n),
    .cmd_write(cmd_write), .cmd_bank(cmd_bank), .cmd_pattern(cmd_pattern),
    .cmd_open(cmd_open), .irq_ack(irq_ack), .dtack(dtack), .busy(busy), .irq(irq),
    .bank_fire(bank_fire), .coil_set(coil_set), .coil_reset(coil_reset));
  rms_host_model u_rms_host_model (.clock(clock), .rst_n(rst_n), .dly(dly),
    .irq(irq), .irq_ack(irq_ack));
  // Counts one comparison and reports any difference
  task automatic tally(input logic [35:0] got, input logic [35:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Coil word of one pulse
  task automatic check_entry(input logic [35:0] got, input logic [35:0] exp);
    tally(got, exp);
  endtask
  // Cycle and event counts
  task automatic check_count(input int got, input int exp);
    tally(36'(got), 36'(exp));
  endtask
  // One-bit strobes and levels
  task automatic check_flag(input logic got, input logic exp);
    tally({35'h0, got}, {35'h0, exp});
  endtask
  // One xorshift step of the random source
  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    v = v ^ (v << 5);
    return v;
  endfunction
  task automatic report_and_stop;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Back-to-back writes of n random entries, noting each expected pulse
  task automatic burst(input int n);
    for (int i = 0; i < n; i++) begin
      rng = xorshift(rng);
      notes.push_back({4'h1 << rng[1:0], rng[2] ? 16'h0000 : rng[31:16],
        rng[2] ? rng[31:16] : 16'h0000});
      cmd_bank <= rng[1:0];
      cmd_open <= rng[2];
      cmd_pattern <= rng[31:16];
      cmd_write <= 1'b1;
      @(posedge clock);
    end
    cmd_write <= 1'b0;
  endtask
  // Waits for the list interrupt, then checks the interrupt count and that busy is low
  task automatic list_done(input int exp);
    for (k = 0; k < 800 && !irq; k++) @(posedge clock);
    repeat (20) @(posedge clock);
    check_count(irqs, exp);
    check_flag(busy, 1'b0);
  endtask
  // Watches outputs and takes the oldest note on each new pulse
  always @(posedge clock) begin
    fire_q <= bank_fire;
    w1 <= cmd_write;
    iq <= irq;
    if (irq && !iq) irqs++;
    if (w1 || dtack) check_flag(dtack, w1);
    if (bank_fire != 0) check_flag(busy, 1'b1);
    if (bank_fire !== fire_q && fire_q != 0) begin
      check_count(plen, 10);
      plen = 0;
    end
    if (bank_fire != 0) plen++;
    if (bank_fire != 0 && bank_fire !== fire_q) begin
      coil_word = {bank_fire, coil_set, coil_reset};
      if (notes.size() == 0) check_entry(coil_word, 36'h0);
      else check_entry(coil_word, notes.pop_front());
    end
  end
  initial begin
    #(20000 * 50);
    failures++;
    report_and_stop;
  end
  initial begin
    for (int b = 0; b < 4; b++) notes.push_back({4'h1 << b, 16'h0000, 16'hFFFF});
    repeat (4) @(posedge clock);
    check_entry({bank_fire, coil_set, coil_reset}, 36'h0);
    rst_n <= 1'b1;
    burst(3);
    list_done(1);
    for (int l = 0; l < 4; l++) begin
      dly <= rng[7:4];
      burst(l == 3 ? 16 : 1 + rng[3:0] % 8);
      list_done(l + 2);
    end
    check_count(notes.size(), 0);
    report_and_stop;
  end
endmodule
